/* design/link_tracker.sv */
/*
  Link flag and link address record.
  Assumes set and clear pulses are one clock wide from the sequencer.
*/
`timescale 1ns/10ps
module link_tracker (
  input wire logic clk,
  input wire logic rst_n,
  link_if.owner lk
);
  logic valid_r;
  logic [31:0] vaddr_r;
  logic [31:0] paddr_r;
  logic [2:0] cca_r;
  logic valid_nxt;
  logic addr_eq;

  // ****************************************
  // Link state
  // ****************************************
  assign valid_nxt = lk.set ? 1'b1 : (lk.clr ? 1'b0 : valid_r);
  assign addr_eq = (vaddr_r == lk.cmp_vaddr) && (paddr_r == lk.cmp_paddr) &&
    (cca_r == lk.cmp_cca);
  assign lk.match = valid_r && (addr_eq || !lk.keep_addr);
  assign lk.valid = valid_r;
  assign lk.rec_vaddr = vaddr_r;
  assign lk.rec_paddr = paddr_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_r <= 1'b0;
    end else begin
      valid_r <= valid_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vaddr_r <= 32'h0000_0000;
      paddr_r <= 32'h0000_0000;
      cca_r <= 3'h0;
    end else if (lk.set) begin
      vaddr_r <= lk.set_vaddr & ~psc_pkg::ALIGN_MASK;
      paddr_r <= lk.set_paddr & ~psc_pkg::ALIGN_MASK;
      cca_r <= lk.set_cca;
    end
  end
endmodule // link_tracker

/* design/paired_store_conditional.sv */
/*
  Execution unit for the user-space paired store-conditional, with the link
  flag it depends on and a Wishbone register slave for its controls.
  Assumes requests are only issued while REQ_READY is high, translation and
  memory answer with one-cycle acks, and memory honours MEM_LOCK.
*/
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module paired_store_conditional #(
  parameter bit BIG_ENDIAN = 1'b0
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic REQ_VALID,
  input wire psc_pkg::req_kind_t REQ_KIND,
  input wire logic [31:0] REQ_BASE,
  input wire logic [31:0] REQ_HI,
  input wire logic [31:0] REQ_LO,
  input wire logic [31:0] REQ_LL_PADDR,
  input wire logic [2:0] REQ_LL_CCA,
  input wire psc_pkg::seg_mode_t REQ_SEG_MODE,
  input wire logic EXC_TAKEN,
  input wire logic ERET_DONE,
  input wire logic SNOOP_INV,
  output logic REQ_READY,
  output logic RSP_VALID,
  output logic RSP_WE,
  output logic [31:0] RSP_DATA,
  output psc_pkg::exc_t RSP_EXC,
  output logic XLT_REQ,
  output logic [31:0] XLT_VADDR,
  output logic XLT_USER_MAP,
  input wire logic XLT_ACK,
  input wire logic [31:0] XLT_PADDR,
  input wire logic [2:0] XLT_CCA,
  input wire psc_pkg::exc_t XLT_EXC,
  output logic MEM_REQ,
  output logic MEM_LOCK,
  output logic [31:0] MEM_ADDR,
  output logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_XLATE = 3'b001,
    ST_WR_LO = 3'b010,
    ST_WR_HI = 3'b011,
    ST_RESP = 3'b100
  } state_t;

  state_t state_r;
  state_t state_nxt;
  logic [31:0] vaddr_r;
  logic [31:0] hi_r;
  logic [31:0] lo_r;
  logic [31:0] paddr_r;
  logic ok_r;
  logic ok_nxt;
  psc_pkg::exc_t exc_r;
  psc_pkg::exc_t exc_nxt;
  logic [2:0] ctrl_r;
  logic last_ok_r;
  logic ready_r;
  logic rsp_valid_r;
  logic rsp_we_r;
  logic [31:0] rsp_data_r;
  psc_pkg::exc_t rsp_exc_r;
  logic xlt_req_r;
  logic [31:0] xlt_vaddr_r;
  logic xlt_user_r;
  logic mem_req_r;
  logic mem_lock_r;
  logic [31:0] mem_addr_r;
  logic [31:0] mem_wdata_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;

  link_if lk();

  // ****************************************
  // Submodules
  // ****************************************
  logic chk_enabled;
  logic chk_misaligned;
  logic chk_user_map;

  link_tracker u_link (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .lk(lk)
  );

  sc_addr_check u_check (
    .nopair(ctrl_r[psc_pkg::CTRL_NOPAIR_BIT]),
    .eva(ctrl_r[psc_pkg::CTRL_EVA_BIT]),
    .vaddr(REQ_BASE),
    .seg_mode(REQ_SEG_MODE),
    .enabled(chk_enabled),
    .misaligned(chk_misaligned),
    .user_map(chk_user_map)
  );

  // ****************************************
  // Request decode
  // ****************************************
  wire req_take = REQ_VALID && ready_r;
  wire take_sc = req_take && (REQ_KIND == psc_pkg::KIND_SC_PAIRED_USER);
  wire take_ll = req_take && ((REQ_KIND == psc_pkg::KIND_LL_PAIRED) ||
    (REQ_KIND == psc_pkg::KIND_LL_OTHER));
  wire sc_end = (state_r != ST_RESP) && (state_nxt == ST_RESP);
  wire [31:0] lo_ofs = BIG_ENDIAN ? psc_pkg::HI_WORD_OFS : 32'h0000_0000;
  wire [31:0] hi_ofs = BIG_ENDIAN ? 32'h0000_0000 : psc_pkg::HI_WORD_OFS;
  wire [31:0] xlt_base = XLT_PADDR & ~psc_pkg::ALIGN_MASK;

  // Loads leave the link alone; only these events clear it
  assign lk.set = take_ll;
  assign lk.clr = SNOOP_INV || EXC_TAKEN || ERET_DONE || sc_end;
  assign lk.keep_addr = ctrl_r[psc_pkg::CTRL_KEEP_BIT];
  assign lk.set_vaddr = REQ_BASE;
  assign lk.set_paddr = REQ_LL_PADDR;
  assign lk.set_cca = REQ_LL_CCA;
  assign lk.cmp_vaddr = vaddr_r;
  assign lk.cmp_paddr = xlt_base;
  assign lk.cmp_cca = XLT_CCA;

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    ok_nxt = ok_r;
    exc_nxt = exc_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take_sc) begin
          ok_nxt = 1'b0;
          exc_nxt = psc_pkg::EXC_NONE;
          if (!chk_enabled) begin
            exc_nxt = psc_pkg::EXC_RESERVED_INSTR;
            state_nxt = ST_RESP;
          end else if (chk_misaligned) begin
            exc_nxt = psc_pkg::EXC_ADDR_ERROR;
            state_nxt = ST_RESP;
          end else begin
            state_nxt = ST_XLATE;
          end
        end
      end
      ST_XLATE: begin
        if (XLT_ACK) begin
          if (XLT_EXC != psc_pkg::EXC_NONE) begin
            exc_nxt = XLT_EXC;
            state_nxt = ST_RESP;
          end else if (lk.match) begin
            state_nxt = ST_WR_LO;
          end else begin
            state_nxt = ST_RESP;
          end
        end
      end
      ST_WR_LO: begin
        if (MEM_ACK) begin
          state_nxt = ST_WR_HI;
        end
      end
      ST_WR_HI: begin
        if (MEM_ACK) begin
          ok_nxt = 1'b1;
          state_nxt = ST_RESP;
        end
      end
      ST_RESP: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
      ok_r <= 1'b0;
      exc_r <= psc_pkg::EXC_NONE;
      ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ok_r <= ok_nxt;
      exc_r <= exc_nxt;
      ready_r <= (state_nxt == ST_IDLE);
    end
  end

  // Operands captured with the store request
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      vaddr_r <= 32'h0000_0000;
      hi_r <= 32'h0000_0000;
      lo_r <= 32'h0000_0000;
    end else if (take_sc) begin
      vaddr_r <= REQ_BASE;
      hi_r <= REQ_HI;
      lo_r <= REQ_LO;
    end
  end

  // ****************************************
  // Translation port
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      xlt_req_r <= 1'b0;
      xlt_vaddr_r <= 32'h0000_0000;
      xlt_user_r <= 1'b0;
    end else begin
      xlt_req_r <= (state_nxt == ST_XLATE);
      if (take_sc) begin
        xlt_vaddr_r <= REQ_BASE;
        xlt_user_r <= chk_user_map;
      end
    end
  end

  // ****************************************
  // Memory port
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      paddr_r <= 32'h0000_0000;
      mem_req_r <= 1'b0;
      mem_lock_r <= 1'b0;
      mem_addr_r <= 32'h0000_0000;
      mem_wdata_r <= 32'h0000_0000;
    end else begin
      mem_req_r <= (state_nxt == ST_WR_LO) || (state_nxt == ST_WR_HI);
      mem_lock_r <= (state_nxt == ST_WR_LO) || (state_nxt == ST_WR_HI);
      if (state_r == ST_XLATE && state_nxt == ST_WR_LO) begin
        paddr_r <= xlt_base;
        mem_addr_r <= xlt_base | lo_ofs;
        mem_wdata_r <= lo_r;
      end else if (state_r == ST_WR_LO && state_nxt == ST_WR_HI) begin
        mem_addr_r <= paddr_r | hi_ofs;
        mem_wdata_r <= hi_r;
      end
    end
  end

  // ****************************************
  // Pipeline answer
  // ****************************************
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      rsp_valid_r <= 1'b0;
      rsp_we_r <= 1'b0;
      rsp_data_r <= 32'h0000_0000;
      rsp_exc_r <= psc_pkg::EXC_NONE;
      last_ok_r <= 1'b0;
    end else begin
      rsp_valid_r <= sc_end;
      if (sc_end) begin
        rsp_we_r <= (exc_nxt == psc_pkg::EXC_NONE);
        rsp_data_r <= {31'h0000_0000, ok_nxt};
        rsp_exc_r <= exc_nxt;
        last_ok_r <= ok_nxt;
      end else begin
        rsp_we_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // Wishbone register slave
  // ****************************************
  wire wb_req = WB_CYC_I && WB_STB_I && !wb_ack_r;
  wire wb_wr = wb_req && WB_WE_I;
  wire hit_ctrl = (WB_ADR_I == psc_pkg::CTRL_OFS);
  wire hit_status = (WB_ADR_I == psc_pkg::STATUS_OFS);
  wire hit_vaddr = (WB_ADR_I == psc_pkg::LINK_VADDR_OFS);
  wire hit_paddr = (WB_ADR_I == psc_pkg::LINK_PADDR_OFS);
  wire [2:0] status_bits = {last_ok_r, (state_r != ST_IDLE), lk.valid};
  wire [31:0] rd_mux = hit_ctrl ? {29'h0000_0000, ctrl_r} :
    hit_status ? {29'h0000_0000, status_bits} :
    hit_vaddr ? lk.rec_vaddr :
    hit_paddr ? lk.rec_paddr : 32'h0000_0000;

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h0000_0000;
    end else begin
      wb_ack_r <= wb_req;
      if (wb_req) begin
        wb_dat_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      ctrl_r <= psc_pkg::CTRL_RST;
    end else if (wb_wr && hit_ctrl && WB_SEL_I[0]) begin
      ctrl_r <= WB_DAT_I[2:0];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign WB_ACK_O = wb_ack_r;
  assign WB_DAT_O = wb_dat_r;
  assign REQ_READY = ready_r;
  assign RSP_VALID = rsp_valid_r;
  assign RSP_WE = rsp_we_r;
  assign RSP_DATA = rsp_data_r;
  assign RSP_EXC = rsp_exc_r;
  assign XLT_REQ = xlt_req_r;
  assign XLT_VADDR = xlt_vaddr_r;
  assign XLT_USER_MAP = xlt_user_r;
  assign MEM_REQ = mem_req_r;
  assign MEM_LOCK = mem_lock_r;
  assign MEM_ADDR = mem_addr_r;
  assign MEM_WDATA = mem_wdata_r;
endmodule // paired_store_conditional

/* design/sc_addr_check.sv */
/*
  Availability, alignment and mapping decode for the user-space paired store.
  Assumes configuration bits are stable while a store is in flight.
*/
`timescale 1ns/10ps
module sc_addr_check (
  input wire logic nopair,
  input wire logic eva,
  input wire logic [31:0] vaddr,
  input wire psc_pkg::seg_mode_t seg_mode,
  output logic enabled,
  output logic misaligned,
  output logic user_map
);
  // ****************************************
  // Decode
  // ****************************************
  assign enabled = !nopair && eva;
  assign misaligned = |(vaddr & psc_pkg::ALIGN_MASK);
  assign user_map = (seg_mode == psc_pkg::SEG_KERNEL_USER_MAPPED);
endmodule // sc_addr_check

/* inc/link_if.sv */
/*
  Carrier between the store-conditional sequencer and the link tracker.
  Assumes both ends share one clock; the tracker owns the link state.
*/
`timescale 1ns/10ps
interface link_if;
  logic set;
  logic clr;
  logic keep_addr;
  logic [31:0] set_vaddr;
  logic [31:0] set_paddr;
  logic [2:0] set_cca;
  logic [31:0] cmp_vaddr;
  logic [31:0] cmp_paddr;
  logic [2:0] cmp_cca;
  logic valid;
  logic match;
  logic [31:0] rec_vaddr;
  logic [31:0] rec_paddr;
  modport owner(input set, clr, keep_addr, set_vaddr, set_paddr, set_cca,
    cmp_vaddr, cmp_paddr, cmp_cca, output valid, match, rec_vaddr, rec_paddr);
  modport user(output set, clr, keep_addr, set_vaddr, set_paddr, set_cca,
    cmp_vaddr, cmp_paddr, cmp_cca, input valid, match, rec_vaddr, rec_paddr);
endinterface

/* inc/psc_pkg.sv */
/*
  Constants, encodings and register map of the paired store-conditional unit.
  Assumes a 32-bit virtual and physical address and a 3-bit cache attribute.
*/
package psc_pkg;
  // ****************************************
  // Register map (Wishbone byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LINK_VADDR_OFS = 8'h08;
  localparam logic [7:0] LINK_PADDR_OFS = 8'h0C;
  localparam int unsigned CTRL_NOPAIR_BIT = 0;
  localparam int unsigned CTRL_EVA_BIT = 1;
  localparam int unsigned CTRL_KEEP_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam int unsigned ST_LINK_BIT = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_OK_BIT = 2;
  // ****************************************
  // Addressing
  // ****************************************
  localparam logic [31:0] ALIGN_MASK = 32'h0000_0007;
  localparam logic [31:0] HI_WORD_OFS = 32'h0000_0004;
  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    KIND_LL_PAIRED = 2'b00,
    KIND_LL_OTHER = 2'b01,
    KIND_SC_PAIRED_USER = 2'b10,
    KIND_LOAD = 2'b11
  } req_kind_t;
  typedef enum logic [2:0] {
    EXC_NONE = 3'b000,
    EXC_TLB_REFILL = 3'b001,
    EXC_TLB_INVALID = 3'b010,
    EXC_TLB_MODIFIED = 3'b011,
    EXC_RESERVED_INSTR = 3'b100,
    EXC_ADDR_ERROR = 3'b101,
    EXC_WATCH = 3'b110,
    EXC_COP_UNUSABLE = 3'b111
  } exc_t;
  typedef enum logic [1:0] {
    SEG_KERNEL_USER_MAPPED = 2'b00,
    SEG_UNMAPPED_USK = 2'b01,
    SEG_MAPPED_SK = 2'b10,
    SEG_KERNEL_ONLY = 2'b11
  } seg_mode_t;
endpackage

/* verification/psc_properties.sv */
/*
  Port checks for the paired store-conditional unit.
  Assumes one clock domain; bound to the unit at the foot of this file.
*/
`timescale 1ns/10ps
module psc_properties #(
  parameter bit BIG_ENDIAN = 1'b0
) (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire logic REQ_READY,
  input wire psc_pkg::req_kind_t REQ_KIND,
  input wire logic [31:0] REQ_BASE,
  input wire logic [31:0] REQ_HI,
  input wire logic [31:0] REQ_LO,
  input wire psc_pkg::seg_mode_t REQ_SEG_MODE,
  input wire logic RSP_VALID,
  input wire logic RSP_WE,
  input wire logic [31:0] RSP_DATA,
  input wire psc_pkg::exc_t RSP_EXC,
  input wire logic XLT_REQ,
  input wire logic [31:0] XLT_VADDR,
  input wire logic XLT_USER_MAP,
  input wire logic XLT_ACK,
  input wire psc_pkg::exc_t XLT_EXC,
  input wire logic MEM_REQ,
  input wire logic MEM_LOCK,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [31:0] MEM_WDATA,
  input wire logic MEM_ACK
);
  default clocking dc @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic take;
  logic sc_take;
  logic [31:0] hi_r, lo_r, base_r;
  psc_pkg::seg_mode_t seg_r;
  psc_pkg::exc_t xe_r;
  logic [1:0] wr_cnt;
  assign take = REQ_VALID && REQ_READY;
  assign sc_take = take && REQ_KIND == psc_pkg::KIND_SC_PAIRED_USER;
  // Words written since the last request was taken
  always_ff @(posedge REF_CLK) begin
    if (!RST_N || take)
      wr_cnt <= 2'h0;
    else if (MEM_REQ && MEM_ACK)
      wr_cnt <= wr_cnt + 2'h1;
  end
  always_ff @(posedge REF_CLK) begin
    if (sc_take) begin
      hi_r <= REQ_HI;
      lo_r <= REQ_LO;
      base_r <= REQ_BASE;
      seg_r <= REQ_SEG_MODE;
    end
    if (XLT_REQ && XLT_ACK)
      xe_r <= XLT_EXC;
  end
  word_order_a: assert property (
    MEM_REQ && MEM_ACK |-> MEM_WDATA == ((MEM_ADDR[2] ^ BIG_ENDIAN) ? hi_r : lo_r))
    else $error("paired word halves out of place");
  base_addr_a: assert property (
    XLT_REQ |-> XLT_VADDR == base_r)
    else $error("translated address is not the base register");
  dword_addr_a: assert property (
    MEM_REQ && MEM_ACK |-> MEM_ADDR[1:0] == 2'h0 && MEM_ADDR[2] == (wr_cnt[0] ^ BIG_ENDIAN))
    else $error("word write address off the doubleword");
  lock_hold_a: assert property (
    $fell(MEM_LOCK) |-> wr_cnt == 2'h2)
    else $error("lock released before both words were written");
  lock_span_a: assert property (
    MEM_REQ && MEM_ACK && wr_cnt == 2'h0 |=> MEM_REQ && MEM_LOCK)
    else $error("lock dropped between the two words");
  success_writes_a: assert property (
    RSP_VALID && RSP_DATA == 32'h1 |-> wr_cnt == 2'h2 && RSP_WE && RSP_EXC == psc_pkg::EXC_NONE)
    else $error("success reported without both words written");
  failure_clean_a: assert property (
    RSP_VALID && RSP_DATA == 32'h0 |-> wr_cnt == 2'h0)
    else $error("failed store touched memory");
  user_map_a: assert property (
    XLT_REQ |-> XLT_USER_MAP == (seg_r == psc_pkg::SEG_KERNEL_USER_MAPPED))
    else $error("user mapping select wrong for segment");
  misalign_a: assert property (
    sc_take && REQ_BASE[2:0] != 3'h0 |-> ##[1:2] (RSP_VALID && !RSP_WE
      && RSP_EXC inside {psc_pkg::EXC_ADDR_ERROR, psc_pkg::EXC_RESERVED_INSTR}))
    else $error("misaligned store not refused");
  xlt_fault_a: assert property (
    XLT_REQ && XLT_ACK && XLT_EXC != psc_pkg::EXC_NONE
      |-> ##[1:2] (RSP_VALID && !RSP_WE && RSP_EXC == xe_r))
    else $error("translation fault not passed on");
  cover_ok_c: cover property (RSP_VALID && RSP_DATA == 32'h1);
  cover_fail_c: cover property (RSP_VALID && RSP_DATA == 32'h0 && RSP_WE);
  cover_exc_c: cover property (RSP_VALID && RSP_EXC != psc_pkg::EXC_NONE);
endmodule // psc_properties

bind paired_store_conditional psc_properties #(.BIG_ENDIAN(BIG_ENDIAN)) chk (
  .REF_CLK(REF_CLK), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
  .REQ_KIND(REQ_KIND), .REQ_BASE(REQ_BASE), .REQ_HI(REQ_HI), .REQ_LO(REQ_LO),
  .REQ_SEG_MODE(REQ_SEG_MODE), .RSP_VALID(RSP_VALID), .RSP_WE(RSP_WE),
  .RSP_DATA(RSP_DATA), .RSP_EXC(RSP_EXC), .XLT_REQ(XLT_REQ), .XLT_VADDR(XLT_VADDR),
  .XLT_USER_MAP(XLT_USER_MAP), .XLT_ACK(XLT_ACK), .XLT_EXC(XLT_EXC), .MEM_REQ(MEM_REQ),
  .MEM_LOCK(MEM_LOCK), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK));

/* verification/tb_paired_store_conditional.sv */
/*
  Self-checking bench for the paired store-conditional unit.
  Assumes the far-side model and the bound checker.
*/
`timescale 1ns/10ps
module tb_paired_store_conditional;
  typedef struct {
    logic [1:0] ll;
    logic [1:0] ev;
    logic [31:0] va;
    logic [31:0] sa;
    logic pb;
    logic cb;
    psc_pkg::seg_mode_t sg;
    psc_pkg::exc_t xe;
    logic ok;
    psc_pkg::exc_t ee;
  } row_t;
  localparam psc_pkg::exc_t N = psc_pkg::EXC_NONE;
  localparam psc_pkg::seg_mode_t S0 = psc_pkg::SEG_KERNEL_USER_MAPPED;
  localparam psc_pkg::seg_mode_t S1 = psc_pkg::SEG_UNMAPPED_USK;
  localparam psc_pkg::seg_mode_t S2 = psc_pkg::SEG_MAPPED_SK;
  localparam logic [31:0] A = 32'h0000_0108;
  localparam logic [31:0] B = 32'h0000_0110;
  localparam logic [31:0] PMASK = 32'h4000_0000;
  localparam logic [2:0] CCA = 3'h3;
  logic REF_CLK, RST_N, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, REQ_VALID, REQ_READY;
  logic EXC_TAKEN, ERET_DONE, SNOOP_INV, RSP_VALID, RSP_WE, XLT_REQ, XLT_USER_MAP;
  logic XLT_ACK, MEM_REQ, MEM_LOCK, MEM_ACK, slow;
  logic [7:0] WB_ADR_I;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, REQ_BASE, REQ_HI, REQ_LO, REQ_LL_PADDR, RSP_DATA;
  logic [31:0] XLT_VADDR, XLT_PADDR, MEM_ADDR, MEM_WDATA;
  logic [2:0] REQ_LL_CCA, XLT_CCA;
  psc_pkg::req_kind_t REQ_KIND;
  psc_pkg::seg_mode_t REQ_SEG_MODE;
  psc_pkg::exc_t RSP_EXC, XLT_EXC, x_exc;
  row_t rows [10];
  int n_mismatch = 0;
  int n_tests = 0;
  int n_cyc = 0;
  paired_store_conditional dut (
    .REF_CLK, .RST_N, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .REQ_VALID, .REQ_KIND, .REQ_BASE, .REQ_HI, .REQ_LO,
    .REQ_LL_PADDR, .REQ_LL_CCA, .REQ_SEG_MODE, .EXC_TAKEN, .ERET_DONE, .SNOOP_INV,
    .REQ_READY, .RSP_VALID, .RSP_WE, .RSP_DATA, .RSP_EXC, .XLT_REQ, .XLT_VADDR,
    .XLT_USER_MAP, .XLT_ACK, .XLT_PADDR, .XLT_CCA, .XLT_EXC, .MEM_REQ, .MEM_LOCK,
    .MEM_ADDR, .MEM_WDATA, .MEM_ACK);
  xlt_mem_model mdl (
    .clk(REF_CLK), .rst_n(RST_N), .slow, .cca(CCA), .exc(x_exc), .xlt_req(XLT_REQ),
    .xlt_vaddr(XLT_VADDR), .xlt_user_map(XLT_USER_MAP), .xlt_ack(XLT_ACK),
    .xlt_paddr(XLT_PADDR), .xlt_cca(XLT_CCA), .xlt_exc(XLT_EXC), .mem_req(MEM_REQ),
    .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA), .mem_ack(MEM_ACK));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk_v(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_e(input psc_pkg::exc_t got, input psc_pkg::exc_t exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: exception %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("Compares %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge REF_CLK);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} <= {2'h3, we, a, 4'hF, d};
    do begin
      @(posedge REF_CLK);
    end while (WB_ACK_O !== 1'h1);
    q = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'h0;
  endtask
  task automatic issue(input psc_pkg::req_kind_t k, input logic [31:0] a,
                       input psc_pkg::seg_mode_t s);
    @(posedge REF_CLK);
    {REQ_VALID, REQ_BASE} <= {1'h1, a};
    REQ_KIND <= k;
    REQ_SEG_MODE <= s;
    do begin
      @(posedge REF_CLK);
    end while (REQ_READY !== 1'h1);
    REQ_VALID <= 1'h0;
  endtask
  task automatic run_row(input row_t r, input logic [31:0] i);
    int n0;
    logic [31:0] q;
    {REQ_LO, REQ_HI} <= {32'h1111_0000 + i, 32'h2222_0000 + i};
    REQ_LL_PADDR <= (r.va ^ PMASK) ^ {19'h0, r.pb, 12'h0};
    REQ_LL_CCA <= r.cb ? 3'h5 : CCA;
    x_exc <= r.xe;
    if (r.ll != 2'h0)
      issue(psc_pkg::req_kind_t'({1'h0, r.ll[1]}), r.va, r.sg);
    if (r.ev == 2'h3)
      issue(psc_pkg::KIND_LOAD, r.va, r.sg);
    else if (r.ev != 2'h0) begin
      @(posedge REF_CLK);
      {EXC_TAKEN, ERET_DONE} <= {r.ev == 2'h1, r.ev == 2'h2};
      @(posedge REF_CLK);
      {EXC_TAKEN, ERET_DONE} <= 2'h0;
    end
    n0 = mdl.nwr;
    issue(psc_pkg::KIND_SC_PAIRED_USER, r.sa, r.sg);
    while (RSP_VALID !== 1'h1) begin
      @(posedge REF_CLK);
    end
    chk_v(RSP_DATA, {31'h0, r.ok});
    chk_e(RSP_EXC, r.ee);
    chk_v({31'h0, RSP_WE}, {31'h0, r.ee == N});
    chk_v(32'(mdl.nwr - n0), r.ok ? 32'h2 : 32'h0);
    if (r.ok) begin
      chk_v(mdl.mem[r.sa[4:2]], 32'h1111_0000 + i);
      chk_v(mdl.mem[r.sa[4:2] + 3'h1], 32'h2222_0000 + i);
    end
    if (r.xe == r.ee)
      chk_v({31'h0, mdl.um}, {31'h0, r.sg == S0});
    wb(1'h0, psc_pkg::STATUS_OFS, 32'h0, q);
    chk_v(q & 32'h1, 32'h0);
  endtask
  always #5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    n_cyc++;
    if (n_cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    logic [31:0] q;
    row_t r;
    REF_CLK = 1'h0;
    RST_N = 1'h0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, REQ_VALID, EXC_TAKEN, ERET_DONE, SNOOP_INV, slow} = 8'h0;
    {WB_ADR_I, WB_SEL_I, WB_DAT_I, REQ_BASE, REQ_HI, REQ_LO} = 140'h0;
    {REQ_LL_PADDR, REQ_LL_CCA} = 35'h0;
    REQ_KIND = psc_pkg::KIND_LOAD;
    REQ_SEG_MODE = S0;
    x_exc = N;
    rows = '{'{2'h1, 2'h0, A, A, 1'h0, 1'h0, S0, N, 1'h1, N},
             '{2'h0, 2'h0, A, A, 1'h0, 1'h0, S0, N, 1'h0, N},
             '{2'h2, 2'h0, B, B, 1'h0, 1'h0, S1, N, 1'h1, N},
             '{2'h1, 2'h0, A, B, 1'h0, 1'h0, S2, N, 1'h0, N},
             '{2'h1, 2'h1, A, A, 1'h0, 1'h0, S0, N, 1'h0, N},
             '{2'h1, 2'h2, A, A, 1'h0, 1'h0, S0, N, 1'h0, N},
             '{2'h1, 2'h0, A, A, 1'h1, 1'h0, S0, N, 1'h0, N},
             '{2'h1, 2'h0, A, A, 1'h0, 1'h1, S0, N, 1'h0, N},
             '{2'h1, 2'h3, B, B, 1'h0, 1'h0, S2, N, 1'h1, N},
             '{2'h1, 2'h0, A, A + 32'h4, 1'h0, 1'h0, S0, N, 1'h0, psc_pkg::EXC_ADDR_ERROR}};
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'h1;
    wb(1'h0, psc_pkg::CTRL_OFS, 32'h0, q);
    chk_v(q, 32'h6);
    wb(1'h1, 8'h10, 32'hFFFF_FFFF, q);
    wb(1'h0, 8'h10, 32'h0, q);
    chk_v(q, 32'h0);
    foreach (rows[j]) run_row(rows[j], 32'(j));
    for (int e = 1; e < 8; e++) begin
      r = rows[0];
      r.xe = psc_pkg::exc_t'(e[2:0]);
      r.ok = 1'h0;
      r.ee = r.xe;
      if (e != 4 && e != 5)
        run_row(r, 32'(e));
    end
    slow <= 1'h1;
    run_row(rows[0], 32'h9);
    slow <= 1'h0;
    issue(psc_pkg::KIND_LL_PAIRED, A, S0);
    wb(1'h0, psc_pkg::LINK_VADDR_OFS, 32'h0, q);
    chk_v(q, A);
    @(posedge REF_CLK);
    SNOOP_INV <= 1'h1;
    @(posedge REF_CLK);
    SNOOP_INV <= 1'h0;
    wb(1'h0, psc_pkg::STATUS_OFS, 32'h0, q);
    chk_v(q & 32'h1, 32'h0);
    // Mid-run reset with a live link and a changed control word
    issue(psc_pkg::KIND_LL_PAIRED, A, S0);
    wb(1'h1, psc_pkg::CTRL_OFS, 32'h7, q);
    RST_N <= 1'h0;
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'h1;
    wb(1'h0, psc_pkg::STATUS_OFS, 32'h0, q);
    chk_v(q, 32'h0);
    wb(1'h0, psc_pkg::CTRL_OFS, 32'h0, q);
    chk_v(q, 32'h6);
    r = rows[0];
    r.ok = 1'h0;
    r.ee = psc_pkg::EXC_RESERVED_INSTR;
    wb(1'h1, psc_pkg::CTRL_OFS, 32'h7, q);
    run_row(r, 32'h1E);
    wb(1'h1, psc_pkg::CTRL_OFS, 32'h4, q);
    run_row(r, 32'h1F);
    wb(1'h1, psc_pkg::CTRL_OFS, 32'h2, q);
    r = rows[3];
    r.ok = 1'h1;
    run_row(r, 32'h21);
    wb(1'h1, psc_pkg::CTRL_OFS, 32'h6, q);
    run_row(rows[0], 32'h20);
    conclude();
  end
endmodule // tb_paired_store_conditional

/* verification/xlt_mem_model.sv */
/*
  Translation unit and word memory on the far side of the store unit.
  Assumes one clock; slow adds three wait cycles before each ack.
*/
`timescale 1ns/10ps
module xlt_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic [2:0] cca,
  input wire psc_pkg::exc_t exc,
  input wire logic xlt_req,
  input wire logic [31:0] xlt_vaddr,
  input wire logic xlt_user_map,
  output logic xlt_ack,
  output logic [31:0] xlt_paddr,
  output logic [2:0] xlt_cca,
  output psc_pkg::exc_t xlt_exc,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack
);
  localparam logic [31:0] PMASK = 32'h4000_0000;
  logic [31:0] mem [0:7];
  logic um;
  int nwr;
  logic [1:0] xw, mw;
  // Outside an ack the lines show the inverse, never a stale value
  assign xlt_paddr = xlt_ack ? (xlt_vaddr ^ PMASK) : ~(xlt_vaddr ^ PMASK);
  assign xlt_cca = xlt_ack ? cca : ~cca;
  assign xlt_exc = xlt_ack ? exc : psc_pkg::exc_t'(~exc);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xlt_ack <= 1'h0;
      mem_ack <= 1'h0;
      xw <= 2'h0;
      mw <= 2'h0;
      nwr <= 0;
    end else begin
      xlt_ack <= xlt_req && !xlt_ack && xw == {slow, slow};
      xw <= (xlt_req && !xlt_ack && xw != {slow, slow}) ? xw + 2'h1 : 2'h0;
      mem_ack <= mem_req && !mem_ack && mw == {slow, slow};
      mw <= (mem_req && !mem_ack && mw != {slow, slow}) ? mw + 2'h1 : 2'h0;
      // Single master, noncoherent store
      if (mem_req && mem_ack) begin
        mem[mem_addr[4:2]] <= mem_wdata;
        nwr <= nwr + 1;
      end
      if (xlt_req)
        um <= xlt_user_map;
    end
  end
endmodule // xlt_mem_model
